// *** dv/aof_capture_model.sv ***
// Capture logic model: takes formatted words and queues them for the bench.
// Assumes the bench drives its stall controls off the falling edge.
`timescale 1ns/1ps
`default_nettype none
module aof_capture_model (
   // Clock and stall controls.
   input wire logic clk_sys,
   input wire logic hold,
   input wire logic slow,
   // Formatted stream.
   input wire logic out_valid,
   output logic out_ready,
   input wire logic [15:0] out_sample_bits,
   input wire logic out_overrange_flag
);
   logic [16:0] q[$];
   // Slow mode toggles ready so the stream is stalled on every other cycle.
   always @(negedge clk_sys) begin
      out_ready <= !hold && (slow ? !out_ready : 1'b1);
   end
   // A word is taken where valid and ready meet.
   always @(posedge clk_sys) begin
      if (out_valid === 1'b1 && out_ready) q.push_back({out_overrange_flag, out_sample_bits});
   end
endmodule
`default_nettype wire

// *** dv/aof_checker.sv ***
// Port assertions for the converter output format block.
// Assumes it is bound to aof_format and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module aof_checker (
   // Watched ports.
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic spi_cs_n,
   input wire logic spi_sdo_o,
   input wire logic spi_sdo_oe,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [15:0] out_sample_bits,
   input wire logic out_overrange_flag,
   input wire aof_pkg::aof_mode_t output_signalling_select
);
   import aof_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Two pushes into an empty buffer with no drain leave it full.
   sequence push_two_s;
      (in_valid && in_ready && !out_valid) ##1 (in_valid && in_ready && !out_ready);
   endsequence
   // A drain of the only held word with no push beside it.
   sequence pop_last_s;
      out_valid && in_ready && out_ready && !in_valid;
   endsequence
   reset_state_a: assert property (disable iff (1'b0) !rstn |=> !out_valid && in_ready &&
      !spi_sdo_oe && output_signalling_select == AOF_OUT_FULL_SE) else $error("reset state");
   buf_full_a: assert property (push_two_s |=> !in_ready) else $error("buffer not full");
   push_show_a: assert property (in_valid && in_ready |=> out_valid) else $error("word lost");
   pop_empty_a: assert property (pop_last_s |=> !out_valid) else $error("buffer not empty");
   stall_hold_a: assert property (out_valid && !out_ready |=> out_valid &&
      $stable({out_overrange_flag, out_sample_bits})) else $error("word moved in stall");
   mode_code_a: assert property (output_signalling_select != 2'h3) else $error("mode code");
   mode_quiet_a: assert property ((spi_cs_n && rstn)[*8] |=>
      $stable(output_signalling_select)) else $error("mode changed outside frame");
   sdo_drain_a: assert property (spi_sdo_oe |-> !spi_sdo_o && !spi_cs_n)
      else $error("sdo driven high or outside frame");
endmodule
bind aof_format aof_checker chk (.clk_sys, .rstn, .spi_cs_n, .spi_sdo_o, .spi_sdo_oe,
   .in_valid, .in_ready, .out_valid, .out_ready, .out_sample_bits, .out_overrange_flag,
   .output_signalling_select);
`default_nettype wire

// *** dv/aof_format_test.sv ***
// Self-checking bench for the output format block.
// Assumes the checker binds itself and the capture model drains the stream.
`timescale 1ns/1ps
`default_nettype none
module aof_format_test;
   import aof_pkg::*;
   logic clk_sys = 1'b0, rstn = 1'b0, spi_cs_n = 1'b1, spi_sck = 1'b0, spi_sdi = 1'b0;
   logic in_valid = 1'b0, in_overrange_flag = 1'b0, hold = 1'b0, slow = 1'b0;
   logic [15:0] in_sample_bits = 16'h0000;
   logic spi_sdo_o, spi_sdo_oe, in_ready, out_valid, out_ready, out_overrange_flag;
   logic [15:0] out_sample_bits;
   logic [7:0] rd;
   aof_mode_t output_signalling_select;
   int err_count = 0, cmp_count = 0, pcnt = 0;
   wire logic sdo = spi_sdo_oe ? spi_sdo_o : 1'b1; // Pull-up on the open-drain line.
   aof_format uut (.clk_sys, .rstn, .spi_cs_n, .spi_sck, .spi_sdi, .spi_sdo_o, .spi_sdo_oe,
      .in_valid, .in_ready, .in_sample_bits, .in_overrange_flag, .out_valid, .out_ready,
      .out_sample_bits, .out_overrange_flag, .output_signalling_select);
   aof_capture_model cap (.clk_sys, .hold, .slow, .out_valid, .out_ready, .out_sample_bits,
      .out_overrange_flag);
   always #12.5 clk_sys = ~clk_sys;
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Expected word from configuration byte c and pattern phase ph.
   function automatic logic [16:0] fmt(logic [16:0] w, logic [7:0] c, logic ph);
      logic [15:0] r = w[15:0];
      case (c[5:3])
         3'h1: return 17'h00000;
         3'h3: return 17'h1ffff;
         3'h5: return ph ? 17'h0aaaa : 17'h15555;
         3'h7: return ph ? 17'h1ffff : 17'h00000;
         default: ;
      endcase
      if (c[0] && !c[2]) r[15] = ~r[15];
      if (c[2]) r = r ^ 16'haaaa;
      if (c[1]) r[15:1] = r[15:1] ^ {15{r[0]}};
      return {w[16], r};
   endfunction
   // Levels last four cycles so the pin synchroniser sees every edge.
   task automatic spi(input logic [15:0] w);
      @(negedge clk_sys) spi_cs_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         spi_sdi = w[15 - i];
         repeat (4) @(negedge clk_sys);
         if (i >= 8) rd = {rd[6:0], sdo};
         spi_sck = 1'b1;
         repeat (4) @(negedge clk_sys);
         spi_sck = 1'b0;
      end
      repeat (4) @(negedge clk_sys);
      spi_cs_n = 1'b1;
      repeat (8) @(negedge clk_sys);
   endtask
   // Holds valid and data until the edge that takes them; the caller drops valid.
   task automatic push(input logic [16:0] w);
      @(negedge clk_sys);
      in_valid = 1'b1;
      {in_overrange_flag, in_sample_bits} = w;
      while (in_ready !== 1'b1) @(negedge clk_sys);
      @(posedge clk_sys);
      pcnt++;
   endtask
   task automatic idle();
      @(negedge clk_sys) in_valid = 1'b0;
   endtask
   task automatic get(input logic [16:0] exp);
      int n = 0;
      while (cap.q.size() == 0 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      chk("word", cap.q.size() ? cap.q.pop_front() : ~exp, exp);
   endtask
   task automatic t_regs();
      spi(16'h8400);
      chk("format after reset", rd, 8'h00);
      for (int m = 0; m < 4; m++) begin
         spi({8'h03, 6'h00, m[1:0]});
         chk("mode", output_signalling_select, m == 3 ? 0 : m);
      end
      spi(16'h8300);
      chk("mode readback", rd, 8'h03);
      spi(16'h8500);
      chk("unmapped", rd, 8'h00);
   endtask
   task automatic t_format();
      logic [7:0] cfg [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h07};
      foreach (cfg[i]) begin
         spi({8'h04, cfg[i]});
         spi(16'h8400);
         chk("readback", rd, cfg[i]);
         push(17'h18c35);
         idle();
         get(fmt(17'h18c35, cfg[i], 1'b0));
      end
   endtask
   // Capture stalls so two words fill the buffer, then drains, slowly on odd passes only.
   task automatic t_pattern();
      logic [2:0] tp [4] = '{3'h1, 3'h3, 3'h5, 3'h7};
      logic [16:0] e0, e1;
      foreach (tp[i]) begin
         spi({10'h010, tp[i], 3'h7});
         hold = 1'b1;
         e0 = fmt(17'h0abcd, {2'h0, tp[i], 3'h7}, pcnt[0]);
         push(17'h0abcd);
         e1 = fmt(17'h1f00f, {2'h0, tp[i], 3'h7}, pcnt[0]);
         push(17'h1f00f);
         idle();
         chk("ready when full", in_ready, 1'b0);
         hold = 1'b0;
         slow = i[0];
         get(e0);
         get(e1);
      end
   endtask
   task automatic t_swreset();
      spi(16'h0301);
      chk("mode before soft reset", output_signalling_select, 2'h1);
      spi(16'h0080);
      chk("mode after soft reset", output_signalling_select, 2'h0);
      spi(16'h8400);
      chk("format after soft reset", rd, 8'h00);
   endtask
   initial begin
      repeat (3) @(negedge clk_sys);
      rstn = 1'b1;
      t_regs();
      t_format();
      t_pattern();
      t_swreset();
      finish_test();
   end
   // Watchdog well beyond the expected run of some four thousand cycles.
   initial begin
      #1000000;
      err_count++;
      finish_test();
   end
endmodule
`default_nettype wire

// *** hdl/aof_cfg.svh ***
// Constants for the converter output format block: register offsets, field positions,
// reset values and serial frame layout.
// Assumes it is included by bare name from the package and the design module.
`ifndef AOF_CFG_SVH
`define AOF_CFG_SVH
`define AOF_ADDR_RESET 7'h00
`define AOF_ADDR_MODE 7'h03
`define AOF_ADDR_FMT 7'h04
`define AOF_REG_RESET_VAL 8'h00
`define AOF_SWRST_BIT 7
`define AOF_TP_HI 5
`define AOF_TP_LO 3
`define AOF_ABP_BIT 2
`define AOF_SCR_BIT 1
`define AOF_SGN_BIT 0
`define AOF_MODE_HI 1
`define AOF_MODE_LO 0
`define AOF_FRAME_BITS 5'd16
`define AOF_CHECKER_A 17'h15555
`define AOF_ODD_MASK 16'haaaa
`endif

// *** hdl/aof_format.sv ***
// Converter output format block: serial control port, format register and output formatter.
// Assumes a sample source on clk_sys with valid/ready, and capture logic downstream that
// can stall; serial port pins come from another domain and are synchronised here.
// Notes on behaviour
// - Two-bit output signalling field selects full rate, DDR differential or DDR single-ended.
// - Format register at address 04h holds pattern, polarity, scramble and sign bits.
// - Pattern selector 000 passes ordinary conversion results.
// - Selector 001 drives all output bits zero; 011 drives all bits one.
// - Selector 101 alternates overrange plus sample between checkerboard and its complement.
// - Selector 111 alternates overrange plus sample between all zeros and all ones.
// - Alternate polarity bit enables the mode and forces offset binary coding.
// - Scramble bit turns on output data randomisation; clear passes bits plain.
// - Sign select chooses offset binary or two's complement unless polarity overrides.
// - Software reset clears all mode registers to 00h.
// - Each access is sixteen serial bits: read flag, seven address bits, eight data bits.
`timescale 1ns/1ps
`default_nettype none
`include "aof_cfg.svh"
module aof_format (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // Serial control port pins.
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_sdi,
   output logic spi_sdo_o,
   output logic spi_sdo_oe,
   // Raw sample input, offset binary from the core.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [15:0] in_sample_bits,
   input wire logic in_overrange_flag,
   // Formatted output to capture logic.
   output logic out_valid,
   input wire logic out_ready,
   output logic [15:0] out_sample_bits,
   output logic out_overrange_flag,
   // Output signalling mode for the pad drivers.
   output aof_pkg::aof_mode_t output_signalling_select
);
   import aof_pkg::*;

   logic [1:0] cs_sync_q, sdi_sync_q;
   logic [2:0] sck_sync_q;
   logic cs_n, sck_rise;
   aof_sp_t sp_q;
   logic [4:0] bit_cnt_q;
   logic [14:0] shift_q;
   logic rw_q;
   logic [7:0] rd_q;
   logic [7:0] mode_reg_q, fmt_reg_q;
   logic wr_stb;
   logic [2:0] test_pattern_select;
   logic alt_polarity_enable, scramble_enable, signed_format_select;
   logic phase_q;
   logic [16:0] word;
   logic [16:0] buf_q [0:1];
   logic [1:0] cnt_q;
   logic wr_ptr_q, rd_ptr_q;
   logic push, pop;

   // Two flops on each pin; only the serial clock has a third stage, for its edge detector.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cs_sync_q <= 2'h3;
         sck_sync_q <= 3'h0;
         sdi_sync_q <= 2'h0;
      end else begin
         cs_sync_q <= {cs_sync_q[0], spi_cs_n};
         sck_sync_q <= {sck_sync_q[1:0], spi_sck};
         sdi_sync_q <= {sdi_sync_q[0], spi_sdi};
      end
   end
   assign cs_n = cs_sync_q[1];
   assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];

   // Frame sequencer: edges after the sixteenth are ignored until select rises.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sp_q <= AOF_SP_IDLE;
         bit_cnt_q <= 5'h0;
         shift_q <= 15'h0;
      end else if (cs_n) begin
         sp_q <= AOF_SP_IDLE;
         bit_cnt_q <= 5'h0;
      end else begin
         unique case (sp_q)
            AOF_SP_IDLE: begin
               sp_q <= AOF_SP_SHIFT;
            end
            AOF_SP_SHIFT: begin
               if (sck_rise) begin
                  shift_q <= {shift_q[13:0], sdi_sync_q[1]};
                  bit_cnt_q <= bit_cnt_q + 5'h1;
                  if (bit_cnt_q == `AOF_FRAME_BITS - 5'h1) begin
                     sp_q <= AOF_SP_DONE;
                  end
               end
            end
            AOF_SP_DONE: begin
               sp_q <= AOF_SP_DONE;
            end
         endcase
      end
   end

   // A write commits once, when the sixteenth bit has landed and the read flag is low.
   assign wr_stb = (sp_q == AOF_SP_SHIFT) && sck_rise && !cs_n &&
                   (bit_cnt_q == `AOF_FRAME_BITS - 5'h1) && !shift_q[14];

   // Mode registers; the reset command returns all of them to zero at once.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         mode_reg_q <= `AOF_REG_RESET_VAL;
         fmt_reg_q <= `AOF_REG_RESET_VAL;
      end else if (wr_stb) begin
         if (shift_q[13:7] == `AOF_ADDR_RESET && shift_q[6]) begin
            mode_reg_q <= `AOF_REG_RESET_VAL;
            fmt_reg_q <= `AOF_REG_RESET_VAL;
         end else if (shift_q[13:7] == `AOF_ADDR_MODE) begin
            mode_reg_q <= {shift_q[6:0], sdi_sync_q[1]};
         end else if (shift_q[13:7] == `AOF_ADDR_FMT) begin
            fmt_reg_q <= {shift_q[6:0], sdi_sync_q[1]};
         end
      end
   end

   // Read data is loaded after the address byte and shifted out on each later clock edge.
   always_ff @(posedge clk_sys) begin
      if (!rstn || cs_n) begin
         rd_q <= 8'h0;
      end else if (sp_q == AOF_SP_SHIFT && sck_rise) begin
         if (bit_cnt_q == 5'd7) begin
            unique case ({shift_q[5:0], sdi_sync_q[1]})
               `AOF_ADDR_MODE: rd_q <= mode_reg_q;
               `AOF_ADDR_FMT: rd_q <= fmt_reg_q;
               default: rd_q <= 8'h0;
            endcase
         end else begin
            rd_q <= {rd_q[6:0], 1'b0};
         end
      end
   end
   // The read flag is kept from the first rising edge, since the shifter only holds it
   // at its top bit once the fifteenth bit has landed.
   always_ff @(posedge clk_sys) begin
      if (!rstn || cs_n) begin
         rw_q <= 1'b0;
      end else if (sp_q == AOF_SP_SHIFT && sck_rise && bit_cnt_q == 5'h0) begin
         rw_q <= sdi_sync_q[1];
      end
   end

   // Open drain: pull low only for zero bits of a read's data phase.
   assign spi_sdo_o = 1'b0;
   assign spi_sdo_oe = !cs_n && rw_q && (bit_cnt_q >= 5'd8) &&
                       (sp_q == AOF_SP_SHIFT) && !rd_q[7];

   // Field decode; code 11 of the mode field falls back to full rate.
   always_comb begin
      unique case (mode_reg_q[`AOF_MODE_HI:`AOF_MODE_LO])
         2'h1: output_signalling_select = AOF_OUT_DDR_DIFF;
         2'h2: output_signalling_select = AOF_OUT_DDR_SE;
         default: output_signalling_select = AOF_OUT_FULL_SE;
      endcase
   end
   assign test_pattern_select = fmt_reg_q[`AOF_TP_HI:`AOF_TP_LO];
   assign alt_polarity_enable = fmt_reg_q[`AOF_ABP_BIT];
   assign scramble_enable = fmt_reg_q[`AOF_SCR_BIT];
   assign signed_format_select = fmt_reg_q[`AOF_SGN_BIT];

   // Pattern phase toggles once per accepted word so the pattern alternates per word.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         phase_q <= 1'b0;
      end else if (push) begin
         phase_q <= ~phase_q;
      end
   end

   // Word builder; unused selector codes are left to the host to avoid and pass data.
   always_comb begin
      logic [15:0] s;
      s = in_sample_bits;
      if (signed_format_select && !alt_polarity_enable) begin
         s[15] = ~s[15];
      end
      if (alt_polarity_enable) begin
         s = s ^ `AOF_ODD_MASK;
      end
      if (scramble_enable) begin
         s[15:1] = s[15:1] ^ {15{s[0]}};
      end
      unique case (test_pattern_select)
         AOF_TP_ZERO: word = 17'h0;
         AOF_TP_ONE: word = 17'h1ffff;
         AOF_TP_CHECK: word = phase_q ? ~`AOF_CHECKER_A : `AOF_CHECKER_A;
         AOF_TP_ALT: word = {17{phase_q}};
         default: word = {in_overrange_flag, s};
      endcase
   end

   // Two-entry buffer so a stall by capture logic loses no word.
   assign in_ready = (cnt_q != 2'd2);
   assign push = in_valid && in_ready;
   assign out_valid = (cnt_q != 2'd0);
   assign pop = out_valid && out_ready;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q <= 2'd0;
         buf_q[0] <= 17'h0;
         buf_q[1] <= 17'h0;
      end else begin
         if (push) begin
            buf_q[wr_ptr_q] <= word;
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end
   assign out_overrange_flag = buf_q[rd_ptr_q][16];
   assign out_sample_bits = buf_q[rd_ptr_q][15:0];
endmodule
`default_nettype wire

// *** hdl/aof_pkg.sv ***
// Types for the converter output format block.
// Assumes the constants header sits on the include path.
`include "aof_cfg.svh"
package aof_pkg;
   typedef enum logic [2:0] {
      AOF_TP_OFF = 3'h0,
      AOF_TP_ZERO = 3'h1,
      AOF_TP_ONE = 3'h3,
      AOF_TP_CHECK = 3'h5,
      AOF_TP_ALT = 3'h7
   } aof_tp_t;
   typedef enum logic [1:0] {
      AOF_OUT_FULL_SE = 2'h0,
      AOF_OUT_DDR_DIFF = 2'h1,
      AOF_OUT_DDR_SE = 2'h2
   } aof_mode_t;
   typedef enum logic [2:0] {
      AOF_SP_IDLE = 3'b001,
      AOF_SP_SHIFT = 3'b010,
      AOF_SP_DONE = 3'b100
   } aof_sp_t;
endpackage
